/* design/dwsiu_core.sv */
// Double-word shift and index unit with a classic Wishbone register slave
// Operation
// - Count zero means sixteen places; rotates swap words
// - B is upper word, A lower word
// - Shifts keep extend; only arithmetic touch overflow
// - Separation mode never alters shift behaviour
// - Arithmetic left keeps sign, zero fills A
// - Lost bit unlike sign sets overflow
// - Arithmetic right replicates sign into vacated bits
// - Arithmetic right always clears overflow
// - Logical left zero fills, drops top bits
// - Logical right zero fills B top
// - Rotate left feeds B top into A
// - Rotate right feeds A bottom into B
// - Two 16-bit index registers X and Y
// - Memory word adds into index, flags may set
// - Operand address 0 or 1 means A or B (index add only; indexed loads read memory at 0 or 1)
// - Copies write destination, source stays unaltered
// - Decrement index, skip when result is zero
// - Increment index, skip when it wraps zero
// - Indexed load: address plus index, load accumulator
// - Indirect resolved first, address bit 15 cleared
// - Base register added first in separation mode with the base-relative bit set
// - Index value is signed, moves either way
`timescale 1ns/1ps
module dwsiu_core (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [5:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire dwsiu_pkg::dwsiu_bus_t wb_dat_i,
  output      dwsiu_pkg::dwsiu_bus_t wb_dat_o,
  output      logic                  wb_ack_o
);
  import dwsiu_pkg::*;
  `include "dwsiu_params.svh"

  dwsiu_word_t  acc_a_reg;
  dwsiu_word_t  acc_b_reg;
  dwsiu_word_t  oper_reg;
  dwsiu_word_t  base_reg;
  dwsiu_word_t  maddr_reg;
  dwsiu_word_t  instr_reg;
  logic         ext_reg;
  logic         ovf_reg;
  logic         cds_reg;
  logic         brel_reg;
  logic         skip_reg;
  logic         ack_reg;
  dwsiu_bus_t   dat_reg;
  dwsiu_state_t state_reg;

  dwsiu_idx_if idx_bus ();

  // Index register store
  dwsiu_index_regs u_idx (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .port       (idx_bus.store)
  );

  // Byte-lane merge of a 16-bit register
  function automatic dwsiu_word_t merge16(dwsiu_word_t old, dwsiu_bus_t d, logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Address decode
  logic bus_req;
  logic wr_take;
  logic sel_instr;
  logic sel_oper;
  logic sel_a;
  logic sel_b;
  logic sel_x;
  logic sel_y;
  logic sel_flags;
  logic sel_mdata;
  logic sel_base;
  logic sel_maddr;
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_take = bus_req & wb_we_i & ack_reg;
  always_comb
  begin
    sel_instr = 1'b0;
    sel_oper  = 1'b0;
    sel_a     = 1'b0;
    sel_b     = 1'b0;
    sel_x     = 1'b0;
    sel_y     = 1'b0;
    sel_flags = 1'b0;
    sel_mdata = 1'b0;
    sel_base  = 1'b0;
    sel_maddr = 1'b0;
    if (wb_adr_i == `DW_OFF_INSTR)
      sel_instr = 1'b1;
    else if (wb_adr_i == `DW_OFF_OPER)
      sel_oper = 1'b1;
    else if (wb_adr_i == `DW_OFF_ACC_A)
      sel_a = 1'b1;
    else if (wb_adr_i == `DW_OFF_ACC_B)
      sel_b = 1'b1;
    else if (wb_adr_i == `DW_OFF_IDX_X)
      sel_x = 1'b1;
    else if (wb_adr_i == `DW_OFF_IDX_Y)
      sel_y = 1'b1;
    else if (wb_adr_i == `DW_OFF_FLAGS)
      sel_flags = 1'b1;
    else if (wb_adr_i == `DW_OFF_MDATA)
      sel_mdata = 1'b1;
    else if (wb_adr_i == `DW_OFF_BASE)
      sel_base = 1'b1;
    else if (wb_adr_i == `DW_OFF_MADDR)
      sel_maddr = 1'b1;
  end

  // Instruction decode; the held word is used while a sequence runs
  logic        idle;
  logic        start;
  dwsiu_word_t cur;
  logic        is_shift;
  logic        is_xig;
  logic [3:0]  key;
  logic        use_y;
  logic        use_b;
  dwsiu_word_t idx_cur;
  dwsiu_word_t acc_cur;
  assign idle     = (state_reg == ST_IDLE);
  assign start    = wr_take & sel_instr & idle;
  assign cur      = idle ? wb_dat_i[15:0] : instr_reg;
  assign is_shift = (cur[15:10] == `DW_SHF_TOP) && (cur[8:7] == `DW_SHF_MID);
  assign is_xig   = (cur[15:12] == `DW_XIG_TOP) && (cur[10:5] == `DW_XIG_MID);
  assign key      = {cur[4], cur[2:0]};
  assign use_y    = cur[`DW_IDXY_BIT];
  assign use_b    = cur[`DW_ACCB_BIT];
  assign idx_cur  = use_y ? idx_bus.y_q : idx_bus.x_q;
  assign acc_cur  = use_b ? acc_b_reg : acc_a_reg;

  // Shifter over the B:A pair, independent of separation mode
  logic [4:0]  cnt;
  logic        right;
  dwsiu_kind_t kind;
  logic [31:0] pair;
  logic [31:0] sh_res;
  logic        sh_ovf;
  logic [61:0] wide;
  logic [63:0] rot;
  logic        shift_go;
  assign cnt      = (cur[3:0] == 4'h0) ? `DW_CNT_FULL : {1'b0, cur[3:0]};
  assign right    = cur[`DW_DIR_BIT];
  assign kind     = dwsiu_kind_t'(cur[6:4]);
  assign pair     = {acc_b_reg, acc_a_reg};
  assign shift_go = start & is_shift;
  always_comb
  begin
    wide   = '0;
    rot    = '0;
    sh_res = pair;
    sh_ovf = ovf_reg;
    case (kind)
      K_ARITH:
      begin
        if (right)
        begin
          sh_res = 32'($signed(pair) >>> cnt);
          sh_ovf = 1'b0;
        end
        else
        begin
          sh_res = {pair[31], 31'(pair[30:0] << cnt)};
          wide   = {31'h0, pair[30:0] ^ {31{pair[31]}}} << cnt;
          sh_ovf = |wide[61:31];
        end
      end
      K_LOGIC:
        sh_res = right ? (pair >> cnt) : (pair << cnt);
      K_ROT:
      begin
        rot    = right ? ({pair, pair} >> cnt) : ({pair, pair} << cnt);
        sh_res = right ? rot[31:0] : rot[63:32];
      end
      default:
        sh_res = pair;
    endcase
  end

  // Extended group: copies, count-and-skip, adds and indexed loads
  logic        to_idx;
  logic        to_acc;
  logic        dec_go;
  logic        inc_go;
  logic        job_add;
  logic        job_load;
  logic        wr_mdata;
  logic        step;
  logic        fetch_done;
  logic        reg_opnd;
  logic        add_go;
  dwsiu_word_t cand;
  dwsiu_word_t cnt_res;
  dwsiu_word_t base_sum;
  dwsiu_word_t ea_sum;
  dwsiu_word_t add_src;
  dwsiu_word_t add_sum;
  logic        add_c;
  logic        add_v;
  assign to_idx     = start & is_xig & (key == `DW_K_TO_IDX);
  assign to_acc     = start & is_xig & (key == `DW_K_TO_ACC);
  assign dec_go     = start & is_xig & (key == `DW_K_DEC);
  assign inc_go     = start & is_xig & (key == `DW_K_INC);
  assign job_add    = is_xig & (key == `DW_K_ADD);
  assign job_load   = is_xig & (key == `DW_K_LOAD);
  assign wr_mdata   = wr_take & sel_mdata;
  assign step       = (start & (job_add | job_load)) | (wr_mdata & (state_reg == ST_INDIR));
  assign fetch_done = wr_mdata & (state_reg == ST_FETCH);
  assign cand       = idle ? oper_reg : wb_dat_i[15:0];
  assign reg_opnd   = job_add & ~cand[`DW_IND_BIT]
                    & ((cand[14:0] == `DW_ADDR_A) | (cand[14:0] == `DW_ADDR_B));
  assign add_src    = fetch_done ? wb_dat_i[15:0]
                    : ((cand[14:0] == `DW_ADDR_B) ? acc_b_reg : acc_a_reg);
  assign add_go     = (fetch_done & job_add) | (step & reg_opnd);
  assign {add_c, add_sum} = {1'b0, idx_cur} + {1'b0, add_src};
  assign add_v      = (idx_cur[15] == add_src[15]) & (add_sum[15] != idx_cur[15]);
  assign cnt_res    = dec_go ? (idx_cur - `DW_ONE) : (idx_cur + `DW_ONE);
  assign base_sum   = (cds_reg & brel_reg) ? ({1'b0, cand[14:0]} + base_reg)
                    : {1'b0, cand[14:0]};
  assign ea_sum     = base_sum + idx_cur;

  // Index register writes from instructions or software
  always_comb
  begin
    idx_bus.wr_en   = to_idx | dec_go | inc_go | add_go | (wr_take & (sel_x | sel_y));
    idx_bus.wr_y    = (wr_take & (sel_x | sel_y)) ? sel_y : use_y;
    idx_bus.wr_data = cnt_res;
    if (to_idx)
      idx_bus.wr_data = acc_cur;
    else if (add_go)
      idx_bus.wr_data = add_sum;
    else if (wr_take & sel_x)
      idx_bus.wr_data = merge16(idx_bus.x_q, wb_dat_i, wb_sel_i);
    else if (wr_take & sel_y)
      idx_bus.wr_data = merge16(idx_bus.y_q, wb_dat_i, wb_sel_i);
  end

  // Accumulators
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_a_reg <= `DW_RST16;
      acc_b_reg <= `DW_RST16;
    end
    else if (shift_go)
      {acc_b_reg, acc_a_reg} <= sh_res;
    else if (to_acc)
    begin
      if (use_b)
        acc_b_reg <= idx_cur;
      else
        acc_a_reg <= idx_cur;
    end
    else if (fetch_done & job_load)
    begin
      if (use_b)
        acc_b_reg <= wb_dat_i[15:0];
      else
        acc_a_reg <= wb_dat_i[15:0];
    end
    else if (wr_take & sel_a)
      acc_a_reg <= merge16(acc_a_reg, wb_dat_i, wb_sel_i);
    else if (wr_take & sel_b)
      acc_b_reg <= merge16(acc_b_reg, wb_dat_i, wb_sel_i);
  end

  // Extend and overflow flags
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end
    else if (shift_go)
      ovf_reg <= sh_ovf;
    else if (add_go)
    begin
      ext_reg <= ext_reg | add_c;
      ovf_reg <= ovf_reg | add_v;
    end
    else if (wr_take & sel_flags & wb_sel_i[0])
    begin
      ext_reg <= wb_dat_i[`DW_F_EXT];
      ovf_reg <= wb_dat_i[`DW_F_OVF];
    end
  end

  // Mode bits and skip indication
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cds_reg  <= 1'b0;
      brel_reg <= 1'b0;
      skip_reg <= 1'b0;
    end
    else
    begin
      if (start)
        skip_reg <= (dec_go | inc_go) & (cnt_res == `DW_RST16);
      if (wr_take & sel_flags & wb_sel_i[0])
      begin
        cds_reg  <= wb_dat_i[`DW_F_CDS];
        brel_reg <= wb_dat_i[`DW_F_BREL];
      end
    end
  end

  // Operand, base and held instruction words
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      oper_reg  <= `DW_RST16;
      base_reg  <= `DW_RST16;
      instr_reg <= `DW_RST16;
    end
    else
    begin
      if (start)
        instr_reg <= wb_dat_i[15:0];
      if (wr_take & sel_oper & idle)
        oper_reg <= merge16(oper_reg, wb_dat_i, wb_sel_i);
      if (wr_take & sel_base)
        base_reg <= merge16(base_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Operand sequence: indirect chain, then operand fetch
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      maddr_reg <= `DW_RST16;
    end
    else if (step)
    begin
      if (cand[`DW_IND_BIT])
      begin
        state_reg <= ST_INDIR;
        maddr_reg <= {1'b0, cand[14:0]};
      end
      else if (reg_opnd)
        state_reg <= ST_IDLE;
      else
      begin
        state_reg <= ST_FETCH;
        maddr_reg <= job_load ? {1'b0, ea_sum[14:0]} : {1'b0, cand[14:0]};
      end
    end
    else if (fetch_done)
      state_reg <= ST_IDLE;
  end

  // Wishbone answer, one wait cycle per access
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg)
      begin
        dat_reg <= '0;
        if (sel_instr)
          dat_reg[15:0] <= instr_reg;
        else if (sel_oper)
          dat_reg[15:0] <= oper_reg;
        else if (sel_a)
          dat_reg[15:0] <= acc_a_reg;
        else if (sel_b)
          dat_reg[15:0] <= acc_b_reg;
        else if (sel_x)
          dat_reg[15:0] <= idx_bus.x_q;
        else if (sel_y)
          dat_reg[15:0] <= idx_bus.y_q;
        else if (sel_flags)
        begin
          dat_reg[`DW_F_EXT]  <= ext_reg;
          dat_reg[`DW_F_OVF]  <= ovf_reg;
          dat_reg[`DW_F_CDS]  <= cds_reg;
          dat_reg[`DW_F_BREL] <= brel_reg;
          dat_reg[`DW_F_SKIP] <= skip_reg;
          dat_reg[`DW_F_BUSY] <= ~idle;
        end
        else if (sel_base)
          dat_reg[15:0] <= base_reg;
        else if (sel_maddr)
          dat_reg[15:0] <= maddr_reg;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_asr_clears_ovf;
    shift_go && kind == K_ARITH && right |=> !ovf_reg;
  endproperty
  a_asr_clears_ovf: assert property (p_asr_clears_ovf) else $error("asr kept overflow");

  property p_shift_keeps_ext;
    shift_go |=> $stable(ext_reg);
  endproperty
  a_shift_keeps_ext: assert property (p_shift_keeps_ext) else $error("shift moved extend");

  property p_nonarith_keeps_ovf;
    shift_go && kind != K_ARITH |=> $stable(ovf_reg);
  endproperty
  a_nonarith_keeps_ovf: assert property (p_nonarith_keeps_ovf) else $error("ovf moved");

  property p_rot16_swaps;
    shift_go && kind == K_ROT && cur[3:0] == 4'h0
      |=> acc_a_reg == $past(acc_b_reg) && acc_b_reg == $past(acc_a_reg);
  endproperty
  a_rot16_swaps: assert property (p_rot16_swaps) else $error("count zero no swap");

  property p_asl_sign;
    shift_go && kind == K_ARITH && !right |=> acc_b_reg[15] == $past(acc_b_reg[15]);
  endproperty
  a_asl_sign: assert property (p_asl_sign) else $error("asl changed sign");

  property p_lsr16_clears_b;
    shift_go && kind == K_LOGIC && right && cur[3:0] == 4'h0
      |=> acc_b_reg == `DW_RST16 && acc_a_reg == $past(acc_b_reg);
  endproperty
  a_lsr16_clears_b: assert property (p_lsr16_clears_b) else $error("lsr16 wrong");

  property p_dec_skip;
    dec_go |=> skip_reg == ($past(idx_cur) == `DW_ONE);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("dec skip wrong");

  property p_inc_skip;
    inc_go |=> skip_reg == ($past(idx_cur) == `DW_ALL1);
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("inc skip wrong");

  property p_ea_bit15;
    state_reg == ST_FETCH && instr_reg[2:0] == `DW_K_LOAD |-> !maddr_reg[15];
  endproperty
  a_ea_bit15: assert property (p_ea_bit15) else $error("ea bit 15 set");

  property p_copy_keeps_src;
    to_idx |=> acc_a_reg == $past(acc_a_reg) && acc_b_reg == $past(acc_b_reg);
  endproperty
  a_copy_keeps_src: assert property (p_copy_keeps_src) else $error("copy altered src");
endmodule

/* design/dwsiu_params.svh */
// Register offsets, field positions and opcode constants of the shift/index unit
`ifndef DWSIU_PARAMS_SVH
`define DWSIU_PARAMS_SVH
`define DW_ADR_W        6
`define DW_OFF_INSTR    6'h00
`define DW_OFF_OPER     6'h04
`define DW_OFF_ACC_A    6'h08
`define DW_OFF_ACC_B    6'h0C
`define DW_OFF_IDX_X    6'h10
`define DW_OFF_IDX_Y    6'h14
`define DW_OFF_FLAGS    6'h18
`define DW_OFF_MDATA    6'h1C
`define DW_OFF_BASE     6'h20
`define DW_OFF_MADDR    6'h24
`define DW_F_EXT        0
`define DW_F_OVF        1
`define DW_F_CDS        2
`define DW_F_BREL       3
`define DW_F_SKIP       4
`define DW_F_BUSY       5
`define DW_IND_BIT      15
`define DW_DIR_BIT      9
`define DW_ACCB_BIT     11
`define DW_IDXY_BIT     3
`define DW_SHF_TOP      6'h20
`define DW_SHF_MID      2'h0
`define DW_XIG_TOP      4'h8
`define DW_XIG_MID      6'h1F
`define DW_K_TO_IDX     4'h1
`define DW_K_TO_ACC     4'h4
`define DW_K_LOAD       4'h2
`define DW_K_ADD        4'h6
`define DW_K_INC        4'h8
`define DW_K_DEC        4'h9
`define DW_CNT_FULL     5'h10
`define DW_ADDR_A       15'h0000
`define DW_ADDR_B       15'h0001
`define DW_ONE          16'h0001
`define DW_ALL1         16'hFFFF
`define DW_RST16        16'h0000
`endif

/* design/dwsiu_pkg.sv */
// Types shared by the shift/index unit
package dwsiu_pkg;
  typedef logic [15:0] dwsiu_word_t;
  typedef logic [31:0] dwsiu_bus_t;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_INDIR = 3'b010, ST_FETCH = 3'b100} dwsiu_state_t;
  typedef enum logic [2:0] {K_ARITH = 3'b001, K_LOGIC = 3'b010, K_ROT = 3'b100} dwsiu_kind_t;
endpackage

/* design/dwsiu_idx_if.sv */
// Interface between the datapath and the index register store
`timescale 1ns/1ps
interface dwsiu_idx_if;
  import dwsiu_pkg::*;
  logic        wr_en;
  logic        wr_y;
  dwsiu_word_t wr_data;
  dwsiu_word_t x_q;
  dwsiu_word_t y_q;
  modport ctrl  (output wr_en, output wr_y, output wr_data, input x_q, input y_q);
  modport store (input wr_en, input wr_y, input wr_data, output x_q, output y_q);
endinterface

/* design/dwsiu_index_regs.sv */
// Two-entry index register store with combinational read data
`timescale 1ns/1ps
module dwsiu_index_regs (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Datapath side
  dwsiu_idx_if.store port
);
  import dwsiu_pkg::*;
  `include "dwsiu_params.svh"

  dwsiu_word_t q_reg [2];

  // One register per entry, entry 1 is Y
  for (genvar i = 0; i < 2; i++)
  begin : g_ent
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
      if (rst_i)
        q_reg[i] <= `DW_RST16;
      else if (port.wr_en && (port.wr_y == 1'(i)))
        q_reg[i] <= port.wr_data;
    end
  end

  // Read data straight from the store
  assign port.x_q = q_reg[0];
  assign port.y_q = q_reg[1];
endmodule

/* bench/dwsiu_mem_model.sv */
// Main memory model standing beyond the unit's memory port
`timescale 1ns/1ps
module dwsiu_mem_model (
  // Clock
  input  wire logic              core_clk_i,
  // Bench loading port
  input  wire logic              we_i,
  input  wire logic [14:0]       addr_i,
  input  dwsiu_pkg::dwsiu_word_t wdata_i,
  // Read data
  output dwsiu_pkg::dwsiu_word_t data_o
);
  import dwsiu_pkg::*;
  dwsiu_word_t mem [256];
  // Background pattern so stale words never read as zero
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'h5A3C ^ (16'(i) * 16'h0101);
  end
  // Only the bench writes; the unit reads and never alters a word
  always @(posedge core_clk_i)
  begin
    if (we_i)
      mem[addr_i[7:0]] <= wdata_i;
  end
  // Combinational read of the addressed word
  assign data_o = mem[addr_i[7:0]];
endmodule

/* bench/dwsiu_core_bench.sv */
// Self-checking bench for the double-word shift and index unit
`timescale 1ns/1ps
`include "dwsiu_params.svh"
module dwsiu_core_bench;
  import dwsiu_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'h0;
  dwsiu_bus_t  wdat = 32'h00000000;
  dwsiu_bus_t  rdat;
  logic        ack;
  logic        m_we = 1'b0;
  logic [14:0] m_adr = 15'h0000;
  dwsiu_word_t m_wd = 16'h0000;
  dwsiu_word_t m_rd;
  int          fails = 0;
  int          checks = 0;
  dwsiu_bus_t  rd;
  dwsiu_word_t a, b, x, y, s, t, v, ins;
  logic [16:0] sm;
  logic [32:0] sr;
  // Clock at 25 MHz
  always #20 clk = ~clk;
  dwsiu_core dwsiu_core_i (
    .core_clk_i (clk),
    .rst_i      (rst),
    .wb_cyc_i   (cyc),
    .wb_stb_i   (stb),
    .wb_we_i    (we),
    .wb_adr_i   (adr),
    .wb_sel_i   (sel),
    .wb_dat_i   (wdat),
    .wb_dat_o   (rdat),
    .wb_ack_o   (ack)
  );
  dwsiu_mem_model dwsiu_mem_model_i (
    .core_clk_i (clk),
    .we_i       (m_we),
    .addr_i     (m_adr),
    .wdata_i    (m_wd),
    .data_o     (m_rd)
  );
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [5:0] ad, input dwsiu_word_t d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      fails++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Read one register and compare
  task automatic rchk(input logic [5:0] ad, input dwsiu_word_t e);
    wb(1'b0, ad, 16'h0000);
    checks++;
    if (rd !== {16'h0000, e})
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, rd, e);
    end
  endtask
  task automatic setr(input dwsiu_word_t ra, rb, rx, ry);
    wb(1'b1, `DW_OFF_ACC_A, ra);
    wb(1'b1, `DW_OFF_ACC_B, rb);
    wb(1'b1, `DW_OFF_IDX_X, rx);
    wb(1'b1, `DW_OFF_IDX_Y, ry);
  endtask
  task automatic chkr(input dwsiu_word_t ra, rb, rx, ry);
    rchk(`DW_OFF_ACC_A, ra);
    rchk(`DW_OFF_ACC_B, rb);
    rchk(`DW_OFF_IDX_X, rx);
    rchk(`DW_OFF_IDX_Y, ry);
  endtask
  // Place a word in memory through the model's loading port
  task automatic poke(input logic [14:0] ad, input dwsiu_word_t d);
    @(posedge clk);
    m_we <= 1'b1;
    m_adr <= ad;
    m_wd <= d;
    @(posedge clk);
    m_we <= 1'b0;
  endtask
  // Sequencer step: check the address register, fetch, hand the word over
  task automatic serve(input dwsiu_word_t e);
    rchk(`DW_OFF_MADDR, e);
    m_adr <= rd[14:0];
    @(posedge clk);
    wb(1'b1, `DW_OFF_MDATA, m_rd);
  endtask
  function automatic dwsiu_word_t ext(input logic [3:0] op, input logic bs, input logic ys);
    return {4'h8, bs, 6'h1F, op[3], ys, op[2:0]};
  endfunction
  // Expected pair and overflow after a shift or rotate
  function automatic logic [32:0] shf(input dwsiu_word_t i, input dwsiu_bus_t p, input logic o);
    int          n;
    logic [31:0] r;
    logic        ov;
    n = (i[3:0] == 4'h0) ? 16 : int'(i[3:0]);
    ov = o;
    r = p;
    case ({i[9], i[6:4]})
      4'b0001:
      begin
        ov = 1'b0;
        for (int j = 0; j < n; j++)
          if (p[30 - j] != p[31])
            ov = 1'b1;
        r = {p[31], p[30:0] << n};
      end
      4'b1001:
      begin
        r = $signed(p) >>> n;
        ov = 1'b0;
      end
      4'b0010: r = p << n;
      4'b1010: r = p >> n;
      4'b0100: r = (p << n) | (p >> (32 - n));
      4'b1100: r = (p >> n) | (p << (32 - n));
      default: r = p;
    endcase
    return {ov, r};
  endfunction
  // Indexed load through the memory model, optionally indirect
  task automatic ldx(input dwsiu_word_t fl, op2, ea, input logic bs);
    wb(1'b1, `DW_OFF_FLAGS, fl);
    wb(1'b1, `DW_OFF_OPER, op2);
    wb(1'b1, `DW_OFF_INSTR, ext(`DW_K_LOAD, bs, 1'b0));
    if (op2[15])
      serve(op2 & 16'h7FFF);
    serve(ea);
    rchk(`DW_OFF_FLAGS, fl);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    repeat (50000) @(posedge clk);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h633A3D97));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then unmapped offsets read as zero
    for (int o = 0; o <= 60; o += 4)
      rchk(6'(o), 16'h0000);
    // Every direction and kind, count zero first, random pair and flags
    for (int k = 0; k < 24; k++)
    begin
      ins = {6'h20, k[0], 2'h0, 3'(1 << (k / 2 % 3)), (k < 6) ? 4'h0 : 4'($urandom)};
      if (k >= 6 && k < 12)
        ins[3:0] = 4'h1;
      a = 16'($urandom);
      b = 16'($urandom);
      x = 16'($urandom);
      y = 16'($urandom);
      v = 16'($urandom) & 16'h000F;
      setr(a, b, x, y);
      wb(1'b1, `DW_OFF_FLAGS, v);
      wb(1'b1, `DW_OFF_INSTR, ins);
      sr = shf(ins, {b, a}, v[1]);
      chkr(sr[15:0], sr[31:16], x, y);
      rchk(`DW_OFF_FLAGS, {12'h000, v[3:2], sr[32], v[0]});
    end
    // All eight copies between accumulators and index registers
    for (int k = 0; k < 8; k++)
    begin
      a = 16'($urandom);
      b = 16'($urandom);
      x = 16'($urandom);
      y = 16'($urandom);
      setr(a, b, x, y);
      wb(1'b1, `DW_OFF_INSTR, ext(k[2] ? `DW_K_TO_ACC : `DW_K_TO_IDX, k[0], k[1]));
      s = k[0] ? b : a;
      t = k[1] ? y : x;
      if (k[2] && k[0])
        b = t;
      if (k[2] && !k[0])
        a = t;
      if (!k[2] && k[1])
        y = s;
      if (!k[2] && !k[1])
        x = s;
      chkr(a, b, x, y);
    end
    // Increment and decrement at the skip boundary, plus increment from 7FFF and decrement from 0000
    for (int k = 0; k < 8; k++)
    begin
      v = k[2] ? (k[1] ? 16'h0001 : 16'hFFFF) : (k[1] ? 16'h0000 : 16'h7FFF);
      t = k[1] ? v - 16'h0001 : v + 16'h0001;
      wb(1'b1, `DW_OFF_FLAGS, 16'h0000);
      setr(a, b, v, v);
      wb(1'b1, `DW_OFF_INSTR, ext(k[1] ? `DW_K_DEC : `DW_K_INC, 1'b0, k[0]));
      chkr(a, b, k[0] ? v : t, k[0] ? t : v);
      rchk(`DW_OFF_FLAGS, {11'h000, t == 16'h0000, 4'h0});
    end
    // Index add with the accumulators as operand, carry and overflow case first
    for (int k = 0; k < 4; k++)
    begin
      a = (k < 2) ? 16'h8000 : 16'($urandom);
      b = (k < 2) ? 16'h8000 : 16'($urandom);
      x = (k < 2) ? 16'h8000 : 16'($urandom);
      y = 16'($urandom);
      wb(1'b1, `DW_OFF_FLAGS, 16'h0000);
      setr(a, b, x, y);
      wb(1'b1, `DW_OFF_OPER, {15'h0000, k[0]});
      wb(1'b1, `DW_OFF_INSTR, ext(`DW_K_ADD, 1'b0, k[1]));
      s = k[0] ? b : a;
      t = k[1] ? y : x;
      sm = {1'b0, t} + {1'b0, s};
      v = {14'h0000, t[15] == s[15] && sm[15] != t[15], sm[16]};
      if (k[1])
        y = sm[15:0];
      else
        x = sm[15:0];
      chkr(a, b, x, y);
      rchk(`DW_OFF_FLAGS, v);
    end
    // Index add from a memory word, direct
    poke(15'h0040, 16'h7123);
    wb(1'b1, `DW_OFF_FLAGS, 16'h0000);
    setr(a, b, 16'h1000, y);
    wb(1'b1, `DW_OFF_OPER, 16'h0040);
    wb(1'b1, `DW_OFF_INSTR, ext(`DW_K_ADD, 1'b0, 1'b0));
    rchk(`DW_OFF_FLAGS, 16'h0020);
    serve(16'h0040);
    chkr(a, b, 16'h8123, y);
    rchk(`DW_OFF_FLAGS, 16'h0002);
    // Indirect load with base added and a negative index
    poke(15'h0010, 16'h0030);
    poke(15'h0020, 16'hBEEF);
    wb(1'b1, `DW_OFF_BASE, 16'h0100);
    setr(a, b, 16'hFFF0, y);
    ldx(16'h000C, 16'h8010, 16'h0120, 1'b0);
    chkr(16'hBEEF, b, 16'hFFF0, y);
    // Direct load into B, base ignored without separation mode, bit 15 dropped
    poke(15'h0010, 16'h1234);
    setr(a, b, 16'h0020, y);
    ldx(16'h0008, 16'h7FF0, 16'h0010, 1'b1);
    chkr(a, 16'h1234, 16'h0020, y);
    give_verdict();
  end
endmodule
